// ### fcs_defines.svh
// Constants for the flash command sequencer: command codes, unlock addresses,
// identification addresses and values, and operation timing counts.
// Assumes a 200 MHz system clock and a 16-bit CPU address bus.
`ifndef FCS_DEFINES_SVH
`define FCS_DEFINES_SVH

// Unlock addresses, compared on the low 12 bits only.
`define FCS_UNLOCK_ADDR1   12'h555
`define FCS_UNLOCK_ADDR2   12'haaa
// Command data bytes and the lock address.
`define FCS_DATA_UNLOCK1   8'haa
`define FCS_DATA_UNLOCK2   8'h55
`define FCS_CMD_PROGRAM    8'ha0
`define FCS_CMD_ERASE      8'h80
`define FCS_CMD_SECTOR     8'h30
`define FCS_CMD_CHIP       8'h10
`define FCS_CMD_ID_ENTRY   8'h90
`define FCS_CMD_ID_EXIT    8'hf0
`define FCS_CMD_SECURE     8'ha5
`define FCS_SECURE_DATA    8'h00
`define FCS_SECURE_ADDR    16'hff7f
// Identification readout.
`define FCS_ID_MAKER_ADDR  16'hf000
`define FCS_ID_MACRO_ADDR  16'hf001
`define FCS_ID_SIZE_ADDR   16'hf002
`define FCS_ERASED_BYTE    8'hff
// Size codes by capacity.
`define FCS_SIZE_60K       8'h0e
`define FCS_SIZE_32K       8'h07
`define FCS_SIZE_16K       8'h03
`define FCS_SIZE_8K        8'h01
`define FCS_SIZE_4K        8'h00
// Command enable key values.
`define FCS_KEY_ENABLE     4'h3
`define FCS_KEY_RESET      4'hc
// Address map.
`define FCS_ARRAY_BASE     16'h1000
`define FCS_BANK0_BASE     16'h9000
`define FCS_BANK1_BASE     16'h8000
`define FCS_BOOT_OFFSET    16'h8000
// Timing: figures in their own units, cycles at 200 MHz (5 ns).
`define FCS_CLK_MHZ        200
`define FCS_PROG_US        40
`define FCS_ERASE_MS       30
`define FCS_PROG_CYCLES    (`FCS_PROG_US * `FCS_CLK_MHZ)
`define FCS_ERASE_CYCLES   (`FCS_ERASE_MS * 1000 * `FCS_CLK_MHZ)
`define FCS_TIMER_W        24

`endif

// ### fcs_pkg.sv
// Types shared by the flash command sequencer modules.
// Assumes fcs_defines.svh is compiled alongside.
package fcs_pkg;

  // Operating mode of the chip as seen by the sequencer.
  typedef enum logic [1:0] {
    FCS_MODE_CPU    = 2'h0,
    FCS_MODE_SERIAL = 2'h1,
    FCS_MODE_PARA   = 2'h2
  } fcs_mode_t;

  // Sequencer states, Gray coded along the unlock path.
  typedef enum logic [3:0] {
    FCS_IDLE   = 4'h0,
    FCS_UNL1   = 4'h1,
    FCS_UNL2   = 4'h3,
    FCS_PROG   = 4'h2,
    FCS_ERA3   = 4'h6,
    FCS_ERA4   = 4'h7,
    FCS_ERA5   = 4'h5,
    FCS_SEC3   = 4'h4,
    FCS_BUSY   = 4'hc
  } fcs_state_t;

  // Running operation kind.
  typedef enum logic [1:0] {
    FCS_OP_BYTE   = 2'h0,
    FCS_OP_SECTOR = 2'h1,
    FCS_OP_CHIP   = 2'h2,
    FCS_OP_LOCK   = 2'h3
  } fcs_op_t;

endpackage : fcs_pkg

// ### fcs_array.sv
// Flash array storage: one byte per word, registered read data.
// Assumes the sequencer serialises writes and sector or chip clears.
`timescale 1ns/1ps
module fcs_array #(
  parameter int ADDR_W = 16
) (
  // Clock and control.
  input  wire logic              clk,
  input  wire logic              ce,
  // Read port.
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [7:0]        rd_data,
  // Write port.
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [7:0]        wr_data
);

  logic [7:0] mem [0:(1<<ADDR_W)-1];

  // Array write and registered read; erase is a stream of FFH writes.
  always_ff @(posedge clk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end

endmodule : fcs_array

// ### fcs_timer.sv
// Down counter timing a running program, erase or lock operation.
// Assumes a load pulse and counts once per enabled clock.
`timescale 1ns/1ps
module fcs_timer #(
  parameter int W = 24
) (
  // Clock, reset and enable.
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // Load and status.
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              running
);

  logic [W-1:0] remain;
  logic [W-1:0] next_remain;

  // Next count.
  always_comb begin
    next_remain = remain;
    if (load) begin
      next_remain = count;
    end else if (remain != '0) begin
      next_remain = remain - W'(1);
    end
  end

  // Counter register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remain <= '0;
    end else if (ce) begin
      remain <= next_remain;
    end
  end

  assign running = (remain != '0);

endmodule : fcs_timer

// ### fcs_sequencer.sv
// Flash command sequencer: decodes CPU write sequences, runs operations,
// maps banks, serves identification reads and the busy toggle bit.
// Assumes a synchronous CPU bus on clk; mode and key come from registers.
`timescale 1ns/1ps
`include "fcs_defines.svh"

// Function
// - Match only low 12 address bits against unlock addresses.
// - Byte program: unlock pair, A0H, then target address and data.
// - Sector erase: unlock, 80H, unlock, 30H; top nibble picks sector.
// - Chip erase: same but sixth write 555H/10H; array becomes FFH.
// - Unlock pair then 555H/90H enters identification mode.
// - Identification reads give maker, macro and size codes.
// - Size code follows implemented capacity.
// - FF7FH reads FFH when unlocked, other value when locked.
// - F0H anywhere or unlock plus 555H/F0H leaves identification mode.
// - Lock: unlock pair, 555H/A5H, FF7FH/00H; host picks upper bank.
// - Locked: refuse parallel reads, block serial write and loader.
// - Only chip erase clears the lock.
// - Byte program finishes within 40 us.
// - Sector erase finishes within 30 ms.
// - Lock setting finishes within 40 us.
// - Bit 6 inverts on each read while an operation runs.
// - First read after starting gives bit 6 as one.
// - No new sequence accepted while busy.
// - Sector erase only in CPU-run and serial boot modes.
// - Serial boot bank 0 maps array 1000H-7FFFH to 9000H-FFFFH.
// - Sequences act only when key is 0011B; key resets to 1100B.
// - Bank select matters only in serial boot mode.
// - No array reads while an operation runs.
module fcs_sequencer #(
  parameter logic [7:0]  MAKER_CODE   = 8'h5a, // Arbitrary value.
  parameter logic [7:0]  MACRO_CODE   = 8'h3c, // Arbitrary value.
  parameter logic [7:0]  SIZE_CODE    = `FCS_SIZE_60K,
  parameter int          PROG_CYCLES  = `FCS_PROG_CYCLES,
  parameter int          ERASE_CYCLES = `FCS_ERASE_CYCLES
) (
  // Clock, reset and clock enable.
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // CPU bus.
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata,
  output logic             bus_rvalid,
  output logic             bus_refused,
  // Configuration from the flash control register.
  input  wire logic [3:0]  command_enable_key,
  input  wire logic        bank_select,
  input  wire logic [1:0]  op_mode,
  // Status.
  output logic             busy,
  output logic             id_mode,
  output logic             lock_on,
  output logic             serial_write_block
);

  logic       rst_meta;
  logic       rst_n;
  fcs_pkg::fcs_state_t state;
  fcs_pkg::fcs_state_t next_state;
  fcs_pkg::fcs_op_t    op;
  fcs_pkg::fcs_op_t    next_op;
  logic       next_id_mode;
  logic       lock;
  logic       next_lock;
  logic       toggle;
  logic       next_toggle;
  logic [15:0] op_addr;
  logic [15:0] next_op_addr;
  logic [7:0]  op_data;
  logic [7:0]  next_op_data;
  logic [11:0] erase_ptr;
  logic [11:0] next_erase_ptr;
  logic [3:0]  erase_sec;
  logic [3:0]  next_erase_sec;
  logic        erasing;
  logic        next_erasing;
  logic        tmr_load;
  logic [`FCS_TIMER_W-1:0] tmr_count;
  logic        tmr_run;
  logic        arr_we;
  logic [15:0] arr_waddr;
  logic [7:0]  arr_wdata;
  logic [15:0] arr_raddr;
  logic [7:0]  arr_rdata;
  logic [15:0] phys_addr;
  logic        rd_pend;
  logic [1:0]  rd_kind;
  logic [7:0]  rd_id;
  logic        cmd_ok;
  logic        a555;
  logic        aaaa;
  logic        sector_ok;
  logic        in_serial;
  logic        started;

  // Reset release passes two flops so every process sees a clean edge.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  assign in_serial = (op_mode == fcs_pkg::FCS_MODE_SERIAL);

  // Bank mapping: bank 0 in serial boot sees array 1000H-7FFFH at 9000H-FFFFH.
  always_comb begin
    phys_addr = bus_addr;
    if (in_serial && !bank_select && bus_addr[15]) begin
      phys_addr = bus_addr - `FCS_BOOT_OFFSET;
    end
  end

  // Command decode helpers.
  assign cmd_ok    = (command_enable_key == `FCS_KEY_ENABLE);
  assign a555      = (bus_addr[11:0] == `FCS_UNLOCK_ADDR1);
  assign aaaa      = (bus_addr[11:0] == `FCS_UNLOCK_ADDR2);
  assign sector_ok = (op_mode != fcs_pkg::FCS_MODE_PARA);

  // Sequencer next state; a wrong write drops back to idle.
  always_comb begin
    next_state     = state;
    next_op        = op;
    next_id_mode   = id_mode;
    next_lock      = lock;
    next_op_addr   = op_addr;
    next_op_data   = op_data;
    next_erase_ptr = erase_ptr;
    next_erase_sec = erase_sec;
    next_erasing   = erasing;
    tmr_load       = 1'b0;
    tmr_count      = '0;
    started        = 1'b0;
    if (state == fcs_pkg::FCS_BUSY) begin
      // Writes during an operation are ignored, not decoded.
      if (!tmr_run && !tmr_load && !erasing) begin
        next_state = fcs_pkg::FCS_IDLE;
        if (op == fcs_pkg::FCS_OP_LOCK) begin
          next_lock = 1'b1;
        end else if (op == fcs_pkg::FCS_OP_CHIP) begin
          next_lock = 1'b0;
        end
      end
      if (erasing) begin
        next_erase_ptr = erase_ptr + 12'h001;
        if (erase_ptr == 12'hfff) begin
          next_erase_sec = erase_sec + 4'h1;
          if (op == fcs_pkg::FCS_OP_SECTOR || erase_sec == 4'hf) begin
            next_erasing = 1'b0;
          end
        end
      end
    end else if (bus_wr && cmd_ok) begin
      next_state = fcs_pkg::FCS_IDLE;
      unique case (state)
        fcs_pkg::FCS_IDLE: begin
          if (bus_wdata == `FCS_CMD_ID_EXIT) begin
            next_id_mode = 1'b0;
          end else if (a555 && bus_wdata == `FCS_DATA_UNLOCK1) begin
            next_state = fcs_pkg::FCS_UNL1;
          end
        end
        fcs_pkg::FCS_UNL1: begin
          if (aaaa && bus_wdata == `FCS_DATA_UNLOCK2) begin
            next_state = fcs_pkg::FCS_UNL2;
          end
        end
        fcs_pkg::FCS_UNL2: begin
          if (a555) begin
            unique case (bus_wdata)
              `FCS_CMD_PROGRAM:  next_state = fcs_pkg::FCS_PROG;
              `FCS_CMD_ERASE:    next_state = fcs_pkg::FCS_ERA3;
              `FCS_CMD_ID_ENTRY: next_id_mode = 1'b1;
              `FCS_CMD_ID_EXIT:  next_id_mode = 1'b0;
              `FCS_CMD_SECURE:   next_state = fcs_pkg::FCS_SEC3;
              default:           next_state = fcs_pkg::FCS_IDLE;
            endcase
          end
        end
        fcs_pkg::FCS_PROG: begin
          // Serial boot with the lock on refuses flash writes.
          if (!(lock && in_serial)) begin
            next_state   = fcs_pkg::FCS_BUSY;
            next_op      = fcs_pkg::FCS_OP_BYTE;
            next_op_addr = phys_addr;
            next_op_data = bus_wdata;
            tmr_load     = 1'b1;
            tmr_count    = `FCS_TIMER_W'(PROG_CYCLES);
            started      = 1'b1;
          end
        end
        fcs_pkg::FCS_ERA3: begin
          if (a555 && bus_wdata == `FCS_DATA_UNLOCK1) begin
            next_state = fcs_pkg::FCS_ERA4;
          end
        end
        fcs_pkg::FCS_ERA4: begin
          if (aaaa && bus_wdata == `FCS_DATA_UNLOCK2) begin
            next_state = fcs_pkg::FCS_ERA5;
          end
        end
        fcs_pkg::FCS_ERA5: begin
          if (bus_wdata == `FCS_CMD_SECTOR && sector_ok) begin
            next_state     = fcs_pkg::FCS_BUSY;
            next_op        = fcs_pkg::FCS_OP_SECTOR;
            next_erase_sec = phys_addr[15:12];
            next_erase_ptr = 12'h000;
            next_erasing   = 1'b1;
            tmr_load       = 1'b1;
            tmr_count      = `FCS_TIMER_W'(ERASE_CYCLES);
            started        = 1'b1;
          end else if (a555 && bus_wdata == `FCS_CMD_CHIP) begin
            next_state     = fcs_pkg::FCS_BUSY;
            next_op        = fcs_pkg::FCS_OP_CHIP;
            next_erase_sec = 4'(`FCS_ARRAY_BASE >> 12);
            next_erase_ptr = 12'h000;
            next_erasing   = 1'b1;
            tmr_load       = 1'b1;
            tmr_count      = `FCS_TIMER_W'(ERASE_CYCLES);
            started        = 1'b1;
          end
        end
        fcs_pkg::FCS_SEC3: begin
          if (bus_addr == `FCS_SECURE_ADDR && bus_wdata == `FCS_SECURE_DATA) begin
            next_state = fcs_pkg::FCS_BUSY;
            next_op    = fcs_pkg::FCS_OP_LOCK;
            tmr_load   = 1'b1;
            tmr_count  = `FCS_TIMER_W'(PROG_CYCLES);
            started    = 1'b1;
          end
        end
        default: next_state = fcs_pkg::FCS_IDLE;
      endcase
    end
  end

  // Busy toggle: first read after a start shows one, then inverts per read.
  always_comb begin
    next_toggle = toggle;
    if (started) begin
      next_toggle = 1'b1;
    end else if (state == fcs_pkg::FCS_BUSY && bus_rd) begin
      next_toggle = ~toggle;
    end
  end

  // Sequencer registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= fcs_pkg::FCS_IDLE;
      op        <= fcs_pkg::FCS_OP_BYTE;
      id_mode   <= 1'b0;
      lock      <= 1'b0;
      toggle    <= 1'b1;
      op_addr   <= 16'h0000;
      op_data   <= 8'h00;
      erase_ptr <= 12'h000;
      erase_sec <= 4'h0;
      erasing   <= 1'b0;
    end else if (ce) begin
      state     <= next_state;
      op        <= next_op;
      id_mode   <= next_id_mode;
      lock      <= next_lock;
      toggle    <= next_toggle;
      op_addr   <= next_op_addr;
      op_data   <= next_op_data;
      erase_ptr <= next_erase_ptr;
      erase_sec <= next_erase_sec;
      erasing   <= next_erasing;
    end
  end

  // Array write: program byte each cycle the timer runs with no read pending; erase streams FFH across the sectors.
  // The streamed clear takes 4096 cycles per sector, well inside the timer.
  always_comb begin
    arr_we    = 1'b0;
    arr_waddr = op_addr;
    arr_wdata = op_data;
    if (state == fcs_pkg::FCS_BUSY && erasing) begin
      arr_we    = 1'b1;
      arr_waddr = {erase_sec, erase_ptr};
      arr_wdata = `FCS_ERASED_BYTE;
    end else if (state == fcs_pkg::FCS_BUSY && op == fcs_pkg::FCS_OP_BYTE
                 && tmr_run && !rd_pend) begin
      arr_we = 1'b1;
    end
  end

  assign arr_raddr = phys_addr;

  // Identification readout for the current read address.
  always_comb begin
    rd_id = 8'h00;
    if (bus_addr == `FCS_ID_MAKER_ADDR) begin
      rd_id = MAKER_CODE;
    end else if (bus_addr == `FCS_ID_MACRO_ADDR) begin
      rd_id = MACRO_CODE;
    end else if (bus_addr == `FCS_ID_SIZE_ADDR) begin
      rd_id = SIZE_CODE;
    end else if (bus_addr == `FCS_SECURE_ADDR) begin
      rd_id = lock ? 8'h00 : `FCS_ERASED_BYTE;
    end
  end

  // Read pipeline: kind 0 array, 1 identification, 2 busy status, 3 refused.
  logic [1:0] next_rd_kind;
  logic [7:0] id_hold;
  always_comb begin
    next_rd_kind = 2'd0;
    if (state == fcs_pkg::FCS_BUSY) begin
      next_rd_kind = 2'd2;
    end else if (lock && op_mode == fcs_pkg::FCS_MODE_PARA) begin
      next_rd_kind = 2'd3;
    end else if (id_mode) begin
      next_rd_kind = 2'd1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend <= 1'b0;
      rd_kind <= 2'd0;
      id_hold <= 8'h00;
    end else if (ce) begin
      rd_pend <= bus_rd;
      rd_kind <= next_rd_kind;
      id_hold <= (next_rd_kind == 2'd2) ? {1'b0, toggle, 6'h00} : rd_id;
    end
  end

  // Read data selection on the registered array output.
  always_comb begin
    unique case (rd_kind)
      2'd0:    bus_rdata = arr_rdata;
      2'd3:    bus_rdata = 8'h00;
      default: bus_rdata = id_hold;
    endcase
  end

  assign bus_rvalid         = rd_pend;
  assign bus_refused        = rd_pend && (rd_kind == 2'd3);
  assign busy               = (state == fcs_pkg::FCS_BUSY);
  assign lock_on            = lock;
  assign serial_write_block = lock && in_serial;

  // Operation timer.
  fcs_timer #(
    .W (`FCS_TIMER_W)
  ) u_timer (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .load    (tmr_load),
    .count   (tmr_count),
    .running (tmr_run)
  );

  // Array storage.
  fcs_array #(
    .ADDR_W (16)
  ) u_array (
    .clk     (clk),
    .ce      (ce),
    .rd_addr (arr_raddr),
    .rd_data (arr_rdata),
    .wr_en   (arr_we),
    .wr_addr (arr_waddr),
    .wr_data (arr_wdata)
  );

endmodule : fcs_sequencer

// ### fcs_cpu_model.sv
// CPU partner for the flash command sequencer: single-cycle bus strobes.
// Assumes the block samples its inputs on the rising edge of clk.
`timescale 1ns/1ps
module fcs_cpu_model (
  // Clock.
  input  wire logic        clk,
  // Request side.
  output logic             bus_wr,
  output logic             bus_rd,
  output logic [15:0]      bus_addr,
  output logic [7:0]       bus_wdata,
  // Answer side.
  input  wire logic [7:0]  bus_rdata,
  input  wire logic        bus_rvalid,
  input  wire logic        bus_refused
);
  logic [7:0] last_data;
  logic       last_ref;

  // Bus starts quiet.
  initial begin
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
    bus_addr  = 16'h0000;
    bus_wdata = 8'h00;
  end

  // One write; address and data turn over afterwards so nothing stale looks held.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    bus_wr    = 1'b1;
    bus_addr  = a;
    bus_wdata = d;
    @(negedge clk);
    bus_wr    = 1'b0;
    bus_addr  = ~a;
    bus_wdata = ~d;
  endtask : wr

  // One read; the answer is taken in the single cycle it stands.
  task automatic rd(input logic [15:0] a);
    @(negedge clk);
    bus_rd   = 1'b1;
    bus_addr = a;
    @(negedge clk);
    last_data = (bus_rvalid === 1'b1) ? bus_rdata : 8'hxx;
    last_ref  = bus_refused;
    bus_rd    = 1'b0;
    bus_addr  = ~a;
  endtask : rd

  // Unlock pair and a command at 555; h moves the unused top nibble.
  task automatic cmd(input logic [3:0] h, input logic [7:0] c);
    wr({h, 12'h555}, 8'haa);
    wr({h, 12'haaa}, 8'h55);
    wr({h, 12'h555}, c);
  endtask : cmd

  // Six-write erase: unlock, 80, unlock, then a/c.
  task automatic erase(input logic [15:0] a, input logic [7:0] c);
    cmd(4'h1, 8'h80);
    wr(16'h1555, 8'haa);
    wr(16'h1aaa, 8'h55);
    wr(a, c);
  endtask : erase

  // Done only when two reads in a row agree; a bounded number of tries.
  task automatic poll(input logic [15:0] a, output logic ok);
    logic [7:0] prev;
    ok = 1'b0;
    rd(a);
    repeat (40000) begin
      if (!ok) begin
        prev = last_data;
        rd(a);
        ok = (last_data === prev) && (^prev !== 1'bx);
      end
    end
  endtask : poll
endmodule : fcs_cpu_model

// ### fcs_seq_props.sv
// Port-level checks for the flash command sequencer.
// Assumes it is bound to fcs_sequencer and sees only its ports.
`timescale 1ns/1ps
module fcs_seq_props (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        ce,
  // Bus.
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0]  bus_wdata,
  input wire logic [7:0]  bus_rdata,
  input wire logic        bus_rvalid,
  input wire logic        bus_refused,
  // Configuration and status.
  input wire logic [3:0]  command_enable_key,
  input wire logic        bank_select,
  input wire logic [1:0]  op_mode,
  input wire logic        busy,
  input wire logic        id_mode,
  input wire logic        lock_on,
  input wire logic        serial_write_block
);
  // A full chip clear is the longest operation the bench scales down to.
  localparam int BUSY_MAX = 62000;
  logic [16:0] busy_cnt;

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Length of the current busy span; a stuck busy shows up here.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_cnt <= 17'h00000;
    end else begin
      busy_cnt <= busy ? busy_cnt + 17'h00001 : 17'h00000;
    end
  end

  a_read_answer: assert property (bus_rd && ce |=> bus_rvalid)
    else $error("read not answered in one cycle");
  a_busy_read_mask: assert property (bus_rvalid && busy |-> (bus_rdata & 8'hbf) == 8'h00)
    else $error("array data served while busy");
  a_refused_read: assert property (bus_refused |-> bus_rvalid && bus_rdata == 8'h00 && lock_on
    && op_mode == 2'h2)
    else $error("refusal without lock in parallel mode");
  a_serial_block: assert property (serial_write_block == (lock_on && op_mode == 2'h1))
    else $error("serial write block wrong");
  a_busy_cause: assert property ($rose(busy) |-> $past(bus_wr) && $past(command_enable_key) == 4'h3)
    else $error("operation started without keyed write");
  a_busy_bounded: assert property (busy_cnt < BUSY_MAX)
    else $error("operation runs too long");
  a_lock_clear: assert property ($fell(lock_on) |-> $past(busy))
    else $error("lock cleared outside an operation");
  a_lock_set: assert property ($rose(lock_on) |-> $past(busy))
    else $error("lock set outside an operation");
  a_id_entry: assert property ($rose(id_mode) |-> $past(bus_wr) && $past(bus_wdata) == 8'h90
    && $past(bus_addr[11:0]) == 12'h555)
    else $error("identification mode entered wrongly");
  a_id_exit: assert property ($fell(id_mode) |-> $past(bus_wr) && $past(bus_wdata) == 8'hf0)
    else $error("identification mode left wrongly");
endmodule : fcs_seq_props

bind fcs_sequencer fcs_seq_props chk_u (
  .clk(clk), .arst_n(arst_n), .ce(ce), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
  .bus_rvalid(bus_rvalid), .bus_refused(bus_refused),
  .command_enable_key(command_enable_key), .bank_select(bank_select), .op_mode(op_mode),
  .busy(busy), .id_mode(id_mode), .lock_on(lock_on), .serial_write_block(serial_write_block)
);

// ### flash_command_sequencer_test.sv
// Self-checking bench for the flash command sequencer with a CPU partner.
// Assumes the partner and checker files are compiled before this one.
`timescale 1ns/1ps
`include "fcs_defines.svh"
module flash_command_sequencer_test;
  localparam int PROG = 50;
  typedef struct packed { logic [15:0] a; logic [7:0] e; } fcs_row_t;
  // Identification rows; maker and macro values are arbitrary.
  localparam fcs_row_t ROWS [5] = '{'{16'hf000, 8'h5a}, '{16'hf001, 8'h3c},
    '{16'hf002, 8'h0e}, '{16'hff7f, 8'hff}, '{16'hf003, 8'h00}};
  logic        clk = 1'b0;
  logic        arst_n, ce, bus_wr, bus_rd, bus_rvalid, bus_refused, bank_select;
  logic        busy, id_mode, lock_on, serial_write_block, ok;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata, bus_rdata;
  logic [3:0]  key;
  logic [1:0]  op_mode;
  int          err_total = 0;
  int          num_checks = 0;
  realtime     t0;

  always #2.5 clk = ~clk;

  fcs_sequencer #(.PROG_CYCLES(PROG), .ERASE_CYCLES(300)) dut_u (
    .clk(clk), .arst_n(arst_n), .ce(ce), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid), .bus_refused(bus_refused), .command_enable_key(key),
    .bank_select(bank_select), .op_mode(op_mode), .busy(busy), .id_mode(id_mode),
    .lock_on(lock_on), .serial_write_block(serial_write_block));
  fcs_cpu_model cpu_u (.clk(clk), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .bus_refused(bus_refused));

  // Counts a comparison and hands back whether it went wrong.
  function automatic bit ck(input bit bad);
    num_checks++;
    return bad;
  endfunction : ck

  task automatic fail(input string m);
    err_total++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask : fail

  task automatic wrap_up;
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // Cycles since t0, for the completion bounds.
  function automatic int since;
    return int'(($realtime - t0) / 5.0);
  endfunction : since

  // The chip clear dominates the run at about 62000 cycles.
  initial begin
    #480us;
    fail("watchdog expired");
    wrap_up();
  end

  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    key = `FCS_KEY_RESET;
    bank_select = 1'b0;
    op_mode = fcs_pkg::FCS_MODE_CPU;
    repeat (8) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    repeat (3) @(negedge clk);
    if (ck(busy !== 1'b0 || id_mode !== 1'b0 || lock_on !== 1'b0)) fail("reset state");
    // Identification loop first; it has to wait for the key like everything else.
    cpu_u.cmd(4'h1, 8'h90);
    if (ck(id_mode !== 1'b0)) fail("entry with key off");
    @(negedge clk) key = `FCS_KEY_ENABLE;
    ce = 1'b0;
    cpu_u.cmd(4'h3, 8'h90);
    if (ck(id_mode !== 1'b0)) fail("write taken while frozen");
    @(negedge clk) ce = 1'b1;
    cpu_u.cmd(4'hc, 8'h90);
    if (ck(id_mode !== 1'b1)) fail("no id mode");
    foreach (ROWS[i]) begin
      cpu_u.rd(ROWS[i].a);
      if (ck(cpu_u.last_data !== ROWS[i].e)) fail("id readout");
    end
    cpu_u.wr(16'h2345, 8'hf0);
    if (ck(id_mode !== 1'b0)) fail("single exit");
    // A broken second write must drop the sequence.
    cpu_u.wr(16'h1555, 8'haa);
    cpu_u.wr(16'h1aaa, 8'h54);
    cpu_u.wr(16'h1555, 8'ha0);
    cpu_u.wr(16'h1234, 8'h3c);
    if (ck(busy !== 1'b0)) fail("mismatch accepted");
    // Program with toggle reads, a refused sequence while busy, then polling.
    cpu_u.cmd(4'hf, 8'ha0);
    cpu_u.wr(16'h1234, 8'h3c);
    t0 = $realtime;
    if (ck(busy !== 1'b1)) fail("program not started");
    cpu_u.rd(16'h1234);
    if (ck(cpu_u.last_data !== 8'h40)) fail("first toggle");
    cpu_u.rd(16'h1234);
    if (ck(cpu_u.last_data !== 8'h00)) fail("second toggle");
    cpu_u.cmd(4'h1, 8'h90);
    if (ck(id_mode !== 1'b0)) fail("sequence taken while busy");
    cpu_u.poll(16'h1234, ok);
    if (ck(!ok || cpu_u.last_data !== 8'h3c)) fail("program data");
    if (ck(since() > PROG + 8)) fail("program too slow");
    // Lock, then its readout and its effects per mode.
    cpu_u.cmd(4'h1, 8'ha5);
    cpu_u.wr(16'hff7f, 8'h00);
    t0 = $realtime;
    cpu_u.rd(16'hff7f);
    if (ck(cpu_u.last_data !== 8'h40)) fail("lock toggle");
    cpu_u.poll(16'h1234, ok);
    if (ck(!ok || lock_on !== 1'b1 || since() > PROG + 8)) fail("lock set");
    cpu_u.cmd(4'h1, 8'h90);
    cpu_u.rd(16'hff7f);
    if (ck(cpu_u.last_data === 8'hff)) fail("lock status");
    cpu_u.cmd(4'h1, 8'hf0);
    if (ck(id_mode !== 1'b0)) fail("sequence exit");
    @(negedge clk) op_mode = fcs_pkg::FCS_MODE_PARA;
    cpu_u.rd(16'h1234);
    if (ck(cpu_u.last_ref !== 1'b1 || cpu_u.last_data !== 8'h00)) fail("parallel read");
    cpu_u.erase(16'h1234, 8'h30);
    if (ck(busy !== 1'b0)) fail("parallel sector erase");
    @(negedge clk) op_mode = fcs_pkg::FCS_MODE_SERIAL;
    cpu_u.cmd(4'h9, 8'ha0);
    cpu_u.wr(16'hf010, 8'h5a);
    if (ck(serial_write_block !== 1'b1 || busy !== 1'b0)) fail("serial lock");
    // Sector erase keeps the lock; chip erase clears it and the array.
    @(negedge clk) op_mode = fcs_pkg::FCS_MODE_CPU;
    cpu_u.erase(16'h1fff, 8'h30);
    t0 = $realtime;
    cpu_u.poll(16'h1234, ok);
    if (ck(!ok || cpu_u.last_data !== 8'hff || since() > 4500)) fail("sector erase");
    if (ck(lock_on !== 1'b1)) fail("lock lost");
    cpu_u.erase(16'h4555, 8'h10);
    t0 = $realtime;
    cpu_u.poll(16'hff7f, ok);
    if (ck(!ok || cpu_u.last_data !== 8'hff || since() > 62000)) fail("chip erase");
    if (ck(lock_on !== 1'b0)) fail("lock kept");
    // Serial bank 0 writes array 7010 through bus address f010.
    @(negedge clk) op_mode = fcs_pkg::FCS_MODE_SERIAL;
    cpu_u.cmd(4'h9, 8'ha0);
    cpu_u.wr(16'hf010, 8'h5a);
    cpu_u.poll(16'hf010, ok);
    if (ck(!ok || cpu_u.last_data !== 8'h5a)) fail("serial program");
    @(negedge clk) op_mode = fcs_pkg::FCS_MODE_CPU;
    bank_select = 1'b1;
    cpu_u.rd(16'h7010);
    if (ck(cpu_u.last_data !== 8'h5a)) fail("real address");
    cpu_u.rd(16'hf010);
    if (ck(cpu_u.last_data !== 8'hff)) fail("no remap in cpu mode");
    wrap_up();
  end
endmodule : flash_command_sequencer_test
